/* File: verilog/pcfp_top.sv */
// Pulse-decoding programming logic with fuse model
`timescale 1ns/100ps
`default_nettype none
`include "pcfp_consts.svh"
module pcfp_top #(
  parameter int SENS_W = 6
) (
  // Clock and power-on reset
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  // Classified output-pin level from the comparators
  input wire logic PIN_AT_MID,
  input wire logic PIN_AT_HIGH,
  // Fuse array contents, persistent across power cycles
  input wire logic [5:0] FUSE_SENS_IN,
  input wire logic [5:0] FUSE_ZERO_IN,
  input wire logic FUSE_LOCK_IN,
  // Fuse blow strobe and target
  output logic FUSE_BLOW,
  output logic [1:0] FUSE_BLOW_KEY,
  output logic [5:0] FUSE_BLOW_MASK,
  // DAC codes and status
  output pcfp_pkg::pcfp_dac_t DAC_OUT,
  output logic [3:0] PROG_STATE
);
  // Pulse widths are the programmer's duty; the logic only looks at returns to low
  pcfp_pkg::pcfp_state_all_t s_reg;
  pcfp_pkg::pcfp_state_all_t s_next;
  pcfp_pkg::pcfp_level_t lvl;
  logic load_reg;

  // Saturating increment shared by both fields
  function automatic logic [5:0] sat_inc(input logic [5:0] v, input logic [5:0] mx);
    sat_inc = (v >= mx) ? mx : 6'(v + 6'h01);
  endfunction

  // Pin level classifier; high dominates mid
  always_comb
  begin
    if (PIN_AT_HIGH)
      lvl = pcfp_pkg::LVL_HIGH;
    else if (PIN_AT_MID)
      lvl = pcfp_pkg::LVL_MID;
    else
      lvl = pcfp_pkg::LVL_LOW;
  end

  // Next-state logic: pulse acts on its return to low
  always_comb
  begin
    logic ret;
    logic [5:0] addr;
    ret = 1'b0;
    addr = 6'h00;
    s_next = s_reg;
    s_next.blow_pls = 1'b0;
    // Fuses are sampled once after reset; later they only gain bits
    if (load_reg)
    begin
      s_next.sens_fuse = FUSE_SENS_IN;
      s_next.zero_fuse = FUSE_ZERO_IN;
      s_next.lock_fuse = FUSE_LOCK_IN;
    end
    if (lvl != pcfp_pkg::LVL_LOW)
    begin
      if (lvl == pcfp_pkg::LVL_HIGH || s_reg.peak == pcfp_pkg::LVL_LOW)
        s_next.peak = lvl;
    end
    else if (s_reg.peak != pcfp_pkg::LVL_LOW)
    begin
      ret = 1'b1;
      s_next.peak = pcfp_pkg::LVL_LOW;
    end
    if (ret && !s_reg.lock_fuse && !load_reg)
    begin
      case (s_reg.st)
        pcfp_pkg::ST_INIT:
        begin
          if (s_reg.peak == pcfp_pkg::LVL_HIGH)
            s_next.st = pcfp_pkg::ST_SELECT;
        end
        pcfp_pkg::ST_SELECT:
        begin
          if (s_reg.peak == pcfp_pkg::LVL_MID)
          begin
            if (s_reg.key != 3'h7)
              s_next.key = 3'(s_reg.key + 3'h1);
          end
          else if (s_reg.key == `PCFP_KEY_SENS || s_reg.key == `PCFP_KEY_ZERO)
            s_next.st = pcfp_pkg::ST_ADDRESS;
          else
            s_next.st = pcfp_pkg::ST_DONE; // Unknown key: wait for power cycle
        end
        pcfp_pkg::ST_ADDRESS:
        begin
          if (s_reg.key == `PCFP_KEY_SENS)
            addr = s_reg.sens_try;
          else
            addr = s_reg.zero_try;
          if (s_reg.peak == pcfp_pkg::LVL_MID)
          begin
            if (s_reg.key == `PCFP_KEY_SENS)
              s_next.sens_try = sat_inc(s_reg.sens_try, `PCFP_SENS_MAX);
            else
              s_next.zero_try = sat_inc(s_reg.zero_try, `PCFP_ZERO_MAX);
          end
          else
          begin
            // Blow every addressed bit; OR keeps existing fuses
            s_next.blow_pls = 1'b1;
            if (s_reg.key == `PCFP_KEY_SENS)
              s_next.sens_fuse = s_reg.sens_fuse | addr;
            else
            begin
              s_next.zero_fuse = s_reg.zero_fuse | (addr & `PCFP_ZERO_MAX);
              if (addr[`PCFP_LOCK_BIT])
                s_next.lock_fuse = 1'b1;
            end
            s_next.st = pcfp_pkg::ST_DONE; // Power cycle required next
          end
        end
        pcfp_pkg::ST_DONE:
        begin
          s_next.st = pcfp_pkg::ST_DONE;
        end
        default:
        begin
          s_next.st = pcfp_pkg::ST_INIT;
        end
      endcase
    end
  end

  // State register; reset models power-up, try codes clear
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      s_reg <= '{st: pcfp_pkg::ST_INIT, peak: pcfp_pkg::LVL_LOW, key: 3'h0,
                 sens_try: `PCFP_CODE_RST, zero_try: `PCFP_CODE_RST,
                 sens_fuse: 6'h00, zero_fuse: 6'h00, lock_fuse: 1'b0,
                 blow_pls: 1'b0};
      load_reg <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
      load_reg <= 1'b0;
    end
  end

  // Outputs: DAC code is fuse OR temporary code
  always_comb
  begin
    DAC_OUT.sens_code = s_reg.sens_fuse | s_reg.sens_try;
    DAC_OUT.zero_code = (s_reg.zero_fuse | s_reg.zero_try) & `PCFP_ZERO_MAX;
    DAC_OUT.locked = s_reg.lock_fuse;
    FUSE_BLOW = s_reg.blow_pls;
    FUSE_BLOW_KEY = s_reg.key[1:0];
    FUSE_BLOW_MASK = (s_reg.key == `PCFP_KEY_SENS) ? s_reg.sens_fuse :
                     {s_reg.lock_fuse, s_reg.zero_fuse[4:0]};
    PROG_STATE = s_reg.st;
  end

  // Assertions
  property p_fuse_keep;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      !load_reg |=> ((s_reg.sens_fuse & $past(s_reg.sens_fuse)) == $past(s_reg.sens_fuse));
  endproperty
  a_fuse_keep: assert property (p_fuse_keep) else $error("Blown fuse cleared");

  property p_lock_freeze;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      (s_reg.lock_fuse && !load_reg) |=> ($stable(s_reg.sens_try) && $stable(s_reg.st));
  endproperty
  a_lock_freeze: assert property (p_lock_freeze) else $error("Change after lock");

  property p_sat;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      (s_reg.sens_try <= `PCFP_SENS_MAX) && (s_reg.zero_try <= `PCFP_ZERO_MAX);
  endproperty
  a_sat: assert property (p_sat) else $error("Code above maximum");

  property p_init_mid;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      (s_reg.st == pcfp_pkg::ST_INIT && s_reg.peak == pcfp_pkg::LVL_MID)
        |=> s_reg.st == pcfp_pkg::ST_INIT;
  endproperty
  a_init_mid: assert property (p_init_mid) else $error("Mid pulse left initial");

  property p_blow_done;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      s_reg.blow_pls |-> s_reg.st == pcfp_pkg::ST_DONE ##1 !s_reg.blow_pls;
  endproperty
  a_blow_done: assert property (p_blow_done) else $error("Blow strobe misplaced");

  property p_inc;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      (s_reg.st == pcfp_pkg::ST_ADDRESS && s_reg.key == `PCFP_KEY_SENS && lvl == pcfp_pkg::LVL_LOW
       && s_reg.peak == pcfp_pkg::LVL_MID && s_reg.sens_try < `PCFP_SENS_MAX && !s_reg.lock_fuse)
        |=> s_reg.sens_try == 6'($past(s_reg.sens_try) + 6'h01);
  endproperty
  a_inc: assert property (p_inc) else $error("Code did not increment");

  property p_dac;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      DAC_OUT.sens_code == (s_reg.sens_fuse | s_reg.sens_try);
  endproperty
  a_dac: assert property (p_dac) else $error("DAC code mismatch");

  property p_select;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      (s_reg.st == pcfp_pkg::ST_SELECT && lvl == pcfp_pkg::LVL_LOW && s_reg.peak == pcfp_pkg::LVL_HIGH
       && s_reg.key == `PCFP_KEY_SENS && !s_reg.lock_fuse) |=> s_reg.st == pcfp_pkg::ST_ADDRESS;
  endproperty
  a_select: assert property (p_select) else $error("Addressing not entered");

  // Pulse returns that the next-state logic acts on; lock and fuse load mask them
  sequence s_ret_mid;
    lvl == pcfp_pkg::LVL_LOW && s_reg.peak == pcfp_pkg::LVL_MID
      && !s_reg.lock_fuse && !load_reg;
  endsequence

  sequence s_ret_high;
    lvl == pcfp_pkg::LVL_LOW && s_reg.peak == pcfp_pkg::LVL_HIGH
      && !s_reg.lock_fuse && !load_reg;
  endsequence

  property p_init_high;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      (s_reg.st == pcfp_pkg::ST_INIT) ##0 s_ret_high |=> s_reg.st == pcfp_pkg::ST_SELECT;
  endproperty
  a_init_high: assert property (p_init_high) else $error("Select state not entered");

  property p_key_inc;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      (s_reg.st == pcfp_pkg::ST_SELECT && s_reg.key != 3'h7) ##0 s_ret_mid
        |=> s_reg.key == 3'($past(s_reg.key) + 3'h1);
  endproperty
  a_key_inc: assert property (p_key_inc) else $error("Key did not count");

  // An unknown key must not reach addressing, or a stray pulse train could blow fuses
  property p_bad_key;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      (s_reg.st == pcfp_pkg::ST_SELECT && s_reg.key != `PCFP_KEY_SENS
       && s_reg.key != `PCFP_KEY_ZERO) ##0 s_ret_high |=> s_reg.st == pcfp_pkg::ST_DONE;
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("Unknown key not refused");

  property p_zero_inc;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      (s_reg.st == pcfp_pkg::ST_ADDRESS && s_reg.key == `PCFP_KEY_ZERO
       && s_reg.zero_try < `PCFP_ZERO_MAX) ##0 s_ret_mid
        |=> s_reg.zero_try == 6'($past(s_reg.zero_try) + 6'h01);
  endproperty
  a_zero_inc: assert property (p_zero_inc) else $error("Zero code did not increment");

  property p_sens_stop;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      (s_reg.st == pcfp_pkg::ST_ADDRESS && s_reg.key == `PCFP_KEY_SENS
       && s_reg.sens_try == `PCFP_SENS_MAX) ##0 s_ret_mid |=> s_reg.sens_try == `PCFP_SENS_MAX;
  endproperty
  a_sens_stop: assert property (p_sens_stop) else $error("Code passed its maximum");

  // Blow strobe follows the high return by one edge and lasts one cycle
  property p_blow_strobe;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      (s_reg.st == pcfp_pkg::ST_ADDRESS) ##0 s_ret_high
        |=> s_reg.blow_pls && s_reg.st == pcfp_pkg::ST_DONE ##1 !s_reg.blow_pls;
  endproperty
  a_blow_strobe: assert property (p_blow_strobe) else $error("Blow pulse not issued");

  property p_done_hold;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      s_reg.st == pcfp_pkg::ST_DONE |=> s_reg.st == pcfp_pkg::ST_DONE;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("Done state left");

  property p_lock_keep;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      (s_reg.lock_fuse && !load_reg) |=> s_reg.lock_fuse;
  endproperty
  a_lock_keep: assert property (p_lock_keep) else $error("Lock fuse cleared");

  property p_zero_keep;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      !load_reg |=> ((s_reg.zero_fuse & $past(s_reg.zero_fuse)) == $past(s_reg.zero_fuse));
  endproperty
  a_zero_keep: assert property (p_zero_keep) else $error("Zero fuse cleared");
endmodule
`default_nettype wire

/* File: verilog/pcfp_consts.svh */
// Constants of the pulse-coded fuse programmer
`ifndef PCFP_CONSTS_SVH
`define PCFP_CONSTS_SVH
`define PCFP_CLK_MHZ 250
`define PCFP_T_HIGH_MIN_US 30
`define PCFP_T_MID_MIN_US 15
`define PCFP_SENS_MAX 6'h3f
`define PCFP_ZERO_MAX 6'h1f
`define PCFP_KEY_SENS 3'h1
`define PCFP_KEY_ZERO 3'h2
`define PCFP_LOCK_BIT 5
`define PCFP_CODE_RST 6'h00
`endif

/* File: verilog/pcfp_pkg.sv */
// Types of the pulse-coded fuse programmer
`default_nettype none
package pcfp_pkg;
  typedef enum logic [3:0] {
    ST_INIT = 4'h1,
    ST_SELECT = 4'h2,
    ST_ADDRESS = 4'h4,
    ST_DONE = 4'h8
  } pcfp_state_t;
  typedef enum logic [1:0] {
    LVL_LOW = 2'h0,
    LVL_MID = 2'h1,
    LVL_HIGH = 2'h2
  } pcfp_level_t;
  typedef struct packed {
    logic [5:0] sens_code;
    logic [5:0] zero_code;
    logic locked;
  } pcfp_dac_t;
  typedef struct packed {
    pcfp_state_t st;
    pcfp_level_t peak;
    logic [2:0] key;
    logic [5:0] sens_try;
    logic [5:0] zero_try;
    logic [5:0] sens_fuse;
    logic [5:0] zero_fuse;
    logic lock_fuse;
    logic blow_pls;
  } pcfp_state_all_t;
endpackage
`default_nettype wire

/* File: test/pcfp_prog_model.sv */
// External programmer and fuse array facing the fuse programmer
`timescale 1ns/100ps
`default_nettype none
module pcfp_prog_model #(
  parameter int T_ON = 2,
  parameter int T_OFF = 2
) (
  // Clock
  input wire logic clk,
  // Classified pin level
  output logic pin_mid,
  output logic pin_high,
  // Fuse blow request
  input wire logic blow,
  input wire logic [1:0] blow_key,
  input wire logic [5:0] blow_mask,
  // Fuse contents
  output logic [5:0] fuse_sens,
  output logic [5:0] fuse_zero,
  output logic fuse_lock
);
  int n_blow = 0;
  logic [1:0] last_key = 2'h0;
  logic [5:0] last_mask = 6'h00;
  initial
  begin
    {pin_mid, pin_high} = 2'h0;
    {fuse_sens, fuse_zero, fuse_lock} = 13'h0;
  end
  // Mid and high pulses both last T_ON cycles, far below the minimum times; the design does not time them
  task automatic pulse(input logic hi, input int n);
    repeat (n)
    begin
      @(posedge clk);
      #1;
      pin_mid = 1'b1;
      pin_high = hi;
      repeat (T_ON) @(posedge clk);
      #1;
      {pin_mid, pin_high} = 2'h0;
      repeat (T_OFF) @(posedge clk);
    end
  endtask
  // Fuses survive resets; a blow only ever adds bits
  always @(posedge clk)
  begin
    if (blow === 1'b1)
    begin
      n_blow <= n_blow + 1;
      last_key <= blow_key;
      last_mask <= blow_mask;
      if (blow_key == 2'h1)
        fuse_sens <= fuse_sens | blow_mask;
      if (blow_key == 2'h2)
        {fuse_lock, fuse_zero[4:0]} <= {fuse_lock, fuse_zero[4:0]} | blow_mask;
    end
  end
endmodule
`default_nettype wire

/* File: test/test_pcfp_top.sv */
// Self-checking bench of the pulse-coded fuse programmer
`timescale 1ns/100ps
`default_nettype none
module test_pcfp_top;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic mid, high, blow, lock;
  logic [1:0] bkey;
  logic [5:0] bmask, fsens, fzero;
  logic [3:0] state;
  pcfp_pkg::pcfp_dac_t dac;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;
  always #2 clk = ~clk;
  pcfp_top i_dut (.CORE_CLK(clk), .ARST_N(arst_n), .PIN_AT_MID(mid), .PIN_AT_HIGH(high),
    .FUSE_SENS_IN(fsens), .FUSE_ZERO_IN(fzero), .FUSE_LOCK_IN(lock), .FUSE_BLOW(blow),
    .FUSE_BLOW_KEY(bkey), .FUSE_BLOW_MASK(bmask), .DAC_OUT(dac), .PROG_STATE(state));
  pcfp_prog_model i_prog (.clk(clk), .pin_mid(mid), .pin_high(high), .blow(blow),
    .blow_key(bkey), .blow_mask(bmask), .fuse_sens(fsens), .fuse_zero(fzero),
    .fuse_lock(lock));
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Run takes under a thousand cycles; a hang stops here
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      end_sim();
    end
  end
  task automatic tally(input logic ok, input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (!ok)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_dac(input logic [5:0] s, input logic [5:0] z, input logic l);
    pcfp_pkg::pcfp_dac_t e;
    e = '{sens_code: s, zero_code: z, locked: l};
    tally(dac === e, 16'(dac), 16'(e));
  endtask
  task automatic chk_st(input logic [3:0] e);
    tally(state === e, 16'(state), 16'(e));
  endtask
  // Waits past the registered strobe so the model has stored it
  task automatic chk_blow(input int n, input logic [1:0] k, input logic [5:0] m);
    repeat (3) @(posedge clk);
    tally({i_prog.n_blow[7:0], i_prog.last_key, i_prog.last_mask} === {n[7:0], k, m},
      {i_prog.n_blow[7:0], i_prog.last_key, i_prog.last_mask}, {n[7:0], k, m});
  endtask
  // Reset stands for a supply cycle; pins stay low two edges after it
  task automatic power_cycle();
    @(posedge clk);
    #1;
    arst_n = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    arst_n = 1'b1;
    repeat (2) @(posedge clk);
  endtask
  task automatic sel(input int key);
    i_prog.pulse(1'b1, 1);
    i_prog.pulse(1'b0, key);
    i_prog.pulse(1'b1, 1);
  endtask
  task automatic t_init();
    i_prog.pulse(1'b0, 3);
    chk_st(4'h1);
    chk_dac(6'h00, 6'h00, 1'b0);
    i_prog.pulse(1'b1, 1);
    chk_st(4'h2);
    power_cycle();
    sel(3);
    chk_st(4'h8);
    i_prog.pulse(1'b0, 2);
    chk_dac(6'h00, 6'h00, 1'b0);
    power_cycle();
    sel(0);
    chk_st(4'h8);
    power_cycle();
    $display("init test done");
  endtask
  task automatic t_try();
    sel(1);
    chk_st(4'h4);
    for (int i = 1; i <= 3; i++)
    begin
      i_prog.pulse(1'b0, 1);
      chk_dac(6'(i), 6'h00, 1'b0);
    end
    power_cycle();
    chk_dac(6'h00, 6'h00, 1'b0);
    sel(2);
    i_prog.pulse(1'b0, 34);
    chk_dac(6'h00, 6'h1f, 1'b0);
    power_cycle();
    sel(1);
    i_prog.pulse(1'b0, 66);
    chk_dac(6'h3f, 6'h00, 1'b0);
    power_cycle();
    $display("try test done");
  endtask
  task automatic t_blow();
    sel(1);
    i_prog.pulse(1'b0, 4);
    i_prog.pulse(1'b1, 1);
    chk_st(4'h8);
    chk_blow(1, 2'h1, 6'h04);
    power_cycle();
    chk_dac(6'h04, 6'h00, 1'b0);
    sel(1);
    i_prog.pulse(1'b0, 1);
    i_prog.pulse(1'b1, 1);
    chk_blow(2, 2'h1, 6'h05);
    power_cycle();
    sel(2);
    i_prog.pulse(1'b0, 3);
    i_prog.pulse(1'b1, 1);
    chk_blow(3, 2'h2, 6'h03);
    power_cycle();
    chk_dac(6'h05, 6'h03, 1'b0);
    $display("blow test done");
  endtask
  // Lock fuse is set in the array directly, the design cannot address it
  task automatic t_lock();
    #1;
    i_prog.fuse_lock = 1'b1;
    power_cycle();
    chk_dac(6'h05, 6'h03, 1'b1);
    sel(1);
    i_prog.pulse(1'b0, 2);
    i_prog.pulse(1'b1, 1);
    chk_blow(3, 2'h2, 6'h03);
    chk_dac(6'h05, 6'h03, 1'b1);
    $display("lock test done");
  endtask
  initial
  begin
    power_cycle();
    t_init();
    t_try();
    t_blow();
    t_lock();
    end_sim();
  end
endmodule
`default_nettype wire
